// ### rdm_pin_router.sv
`timescale 1ns/1ps
// Contract
// - six pins, two-bit codes, mode dependent
// - continuous sleep/standby mapping
// - continuous synthesizer mapping
// - continuous receive codes 00 and 01
// - continuous receive codes 10 and 11
// - continuous transmit codes 00 to 10
// - continuous transmit code 11
// - packet idle modes codes 00 to 10
// - packet code 11 in all modes
// - packet receive code 10
// - packet transmit codes 00 to 10
// - rx data gated ready to payload-ready
// - continuous data over pin 2 directly
// - tx bit clock, sample on rising
// - no synchroniser gives raw data, no clock
// - cleaned data, recovered clock on pin 1
// - packet mode forces bit synchroniser on
// - queue usable in sleep or standby
// - fixed format when bit 0, length nonzero
// - payload length limits 255, 64, 65
// - nonempty low only when queue empty
// - full high only when queue full
// - sent rises after last bit leaves
module rdm_pin_router (
   // system clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // link clock and reset
   input  wire logic       i_lclk,
   input  wire logic       i_lrst_n,
   // configuration
   input  wire logic [7:0] i_pin_route_config_a,
   input  wire logic [7:0] i_pin_route_config_b,
   input  wire logic [2:0] i_op_mode,
   input  wire logic       i_packet_mode,
   input  wire logic       i_bsync_cfg,
   input  wire logic       i_frame_format_select,
   input  wire logic [7:0] i_frame_length_setting,
   input  wire logic       i_encrypt_en,
   input  wire logic       i_address_en,
   // internal status flags
   input  wire logic       i_mode_ready_flag,
   input  wire logic       i_automatic_mode_indicator,
   input  wire logic       i_synth_locked,
   input  wire logic       i_reference_clock_output,
   input  wire logic       i_sync_match_flag,
   input  wire logic       i_receive_ready_flag,
   input  wire logic       i_transmit_ready_flag,
   input  wire logic       i_queue_empty,
   input  wire logic       i_queue_full,
   input  wire logic       i_queue_threshold_flag,
   input  wire logic       i_checksum_good_flag,
   input  wire logic       i_payload_ready_flag,
   input  wire logic       i_shift_last_bit_out,
   input  wire logic       i_timeout_flag,
   input  wire logic       i_rssi_flag,
   input  wire logic       i_demod_raw,
   // data pin input from the controller
   input  wire logic       i_gp_pin_2,
   // pins
   output logic [5:0]      o_gp_pin,
   output logic            o_gp_pin_2_oe,
   // status
   output logic            o_bsync_active,
   output logic            o_fixed_format,
   output logic            o_length_ok,
   output logic            o_queue_enable,
   output logic            o_tx_bit,
   output logic            o_packet_sent_flag
);
   logic [5:0]  pin_nxt;
   logic [5:0]  pin_r;
   logic        oe_nxt;
   logic        oe_r;
   logic [4:0]  sel [0:5];
   logic [1:0]  code [0:5];
   logic [11:0] route_codes;
   logic [5:0]  sel_val;
   logic        cont;
   logic        rx_gate_r;
   logic        rx_ready_d_r;
   logic        pay_ready_d_r;
   logic        sent_r;
   logic        last_d_r;
   logic        bsync_r;
   logic        fixed_r;
   logic        len_ok_r;
   logic        qen_r;
   logic        txbit_r;
   logic        l_txc;
   logic        l_rxc;
   logic        l_bs;
   logic        l_raw;
   logic        l_pin;
   logic        l_dclk;
   logic        l_rxd;
   logic        l_txb;
   logic        s_dclk;
   logic        s_rxd;
   logic        s_txb;
   logic        pin2_s;
   logic [7:0]  len_max;

   assign cont = ~i_packet_mode;

   assign route_codes = {i_pin_route_config_b[3:0], i_pin_route_config_a};

   // controls into the link domain
   rdm_sync2 #(.W(5)) u_to_link (
      .i_clk   (i_lclk),
      .i_rst_n (i_lrst_n),
      .i_d     ({cont & (i_op_mode == rdm_pkg::RDM_TX),
                 (i_op_mode == rdm_pkg::RDM_RX), // packet rx shares the path
                 bsync_r, i_demod_raw, pin2_s}),
      .o_q     ({l_txc, l_rxc, l_bs, l_raw, l_pin})
   );

   // data pin from outside, two flops
   rdm_sync2 #(.W(1)) u_pin_in (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_d     (i_gp_pin_2),
      .o_q     (pin2_s)
   );

   rdm_link u_link (
      .i_lclk      (i_lclk),
      .i_lrst_n    (i_lrst_n),
      .i_tx_cont   (l_txc),
      .i_rx_cont   (l_rxc),
      .i_bsync_en  (l_bs),
      .i_demod_raw (l_raw),
      .i_pin_data  (l_pin),
      .o_dclk      (l_dclk),
      .o_rx_data   (l_rxd),
      .o_tx_bit    (l_txb)
   );

   // link results back to the system clock
   rdm_sync2 #(.W(3)) u_from_link (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_d     ({l_dclk, l_rxd, l_txb}),
      .o_q     ({s_dclk, s_rxd, s_txb})
   );

   // per-pin signal select table
   generate
      for (genvar p = 0; p < rdm_pkg::RDM_NUM_PINS; p++) begin : g_sel
         assign code[p] = route_codes[2*p +: 2]; // two bits per pin
         always_comb begin
            sel[p] = rdm_pkg::SEL_NONE;
            if (cont) begin
               unique case (i_op_mode)
                  rdm_pkg::RDM_SLEEP, rdm_pkg::RDM_STDBY: begin
                     if (code[p] == 2'h2 && p == 3) sel[p] = rdm_pkg::SEL_AUTO;
                     if (code[p] == 2'h3 && (p == 5 || p == 0)) sel[p] = rdm_pkg::SEL_MRDY;
                     if (code[p] == 2'h0 && p == 5 && i_op_mode == rdm_pkg::RDM_STDBY)
                        sel[p] = rdm_pkg::SEL_CLK;
                  end
                  rdm_pkg::RDM_SYNTH: begin
                     if (code[p] == 2'h0 && p == 5) sel[p] = rdm_pkg::SEL_CLK;
                     if (code[p] == 2'h0 && p == 0) sel[p] = rdm_pkg::SEL_LOCK;
                     if (code[p] == 2'h2 && p == 3) sel[p] = rdm_pkg::SEL_AUTO;
                     if (code[p] == 2'h3 && (p == 5 || p == 0)) sel[p] = rdm_pkg::SEL_MRDY;
                     if (code[p] == 2'h3 && (p == 4 || p == 1)) sel[p] = rdm_pkg::SEL_LOCK;
                  end
                  rdm_pkg::RDM_RX: begin
                     // rx codes 00/01, rx codes 10/11
                     unique case (code[p])
                        2'h0: sel[p] = (p == 5) ? rdm_pkg::SEL_CLK  : (p == 4) ? rdm_pkg::SEL_TOUT :
                                       (p == 3) ? rdm_pkg::SEL_RSSI : (p == 2) ? rdm_pkg::SEL_DATA :
                                       (p == 1) ? rdm_pkg::SEL_DCLK : rdm_pkg::SEL_SYNC;
                        2'h1: sel[p] = (p == 5) ? rdm_pkg::SEL_RSSI : (p == 2) ? rdm_pkg::SEL_DATA :
                                       (p == 0) ? rdm_pkg::SEL_TOUT : rdm_pkg::SEL_RXR;
                        2'h2: sel[p] = (p == 4) ? rdm_pkg::SEL_SYNC : (p == 3) ? rdm_pkg::SEL_AUTO :
                                       (p == 2) ? rdm_pkg::SEL_DATA : (p == 0) ? rdm_pkg::SEL_RSSI :
                                       rdm_pkg::SEL_NONE;
                        2'h3: sel[p] = (p == 5 || p == 0) ? rdm_pkg::SEL_MRDY :
                                       (p == 4) ? rdm_pkg::SEL_LOCK : (p == 3) ? rdm_pkg::SEL_TOUT :
                                       (p == 2) ? rdm_pkg::SEL_DATA : rdm_pkg::SEL_SYNC;
                     endcase
                  end
                  rdm_pkg::RDM_TX: begin
                     // tx codes 00 to 10, tx code 11
                     unique case (code[p])
                        2'h0: sel[p] = (p == 5) ? rdm_pkg::SEL_CLK  : (p == 2) ? rdm_pkg::SEL_DATA :
                                       (p == 1) ? rdm_pkg::SEL_DCLK : (p == 0) ? rdm_pkg::SEL_LOCK :
                                       rdm_pkg::SEL_TXR;
                        2'h1: sel[p] = (p == 5) ? rdm_pkg::SEL_CLK  : (p == 2) ? rdm_pkg::SEL_DATA :
                                       rdm_pkg::SEL_TXR;
                        2'h2: sel[p] = (p == 3) ? rdm_pkg::SEL_AUTO : (p == 2) ? rdm_pkg::SEL_DATA :
                                       rdm_pkg::SEL_NONE;
                        2'h3: sel[p] = (p == 5 || p == 0) ? rdm_pkg::SEL_MRDY :
                                       (p == 3) ? rdm_pkg::SEL_TXR  : (p == 2) ? rdm_pkg::SEL_DATA :
                                       rdm_pkg::SEL_LOCK;
                     endcase
                  end
                  default: sel[p] = rdm_pkg::SEL_NONE;
               endcase
            end else if (i_op_mode <= rdm_pkg::RDM_TX) begin // undefined modes stay low
               unique case (code[p])
                  2'h0: begin
                     if (p == 3) sel[p] = rdm_pkg::SEL_FULL;
                     if (p == 2) sel[p] = rdm_pkg::SEL_NEMP;
                     if (p == 1) sel[p] = rdm_pkg::SEL_LVL;
                     if (p == 5 && i_op_mode != rdm_pkg::RDM_SLEEP) sel[p] = rdm_pkg::SEL_CLK;
                     if (p == 4 && i_op_mode == rdm_pkg::RDM_RX) sel[p] = rdm_pkg::SEL_TOUT;
                     if (p == 4 && i_op_mode == rdm_pkg::RDM_TX) sel[p] = rdm_pkg::SEL_MRDY;
                     if (p == 0 && i_op_mode == rdm_pkg::RDM_RX) sel[p] = rdm_pkg::SEL_CRC;
                     if (p == 0 && i_op_mode == rdm_pkg::RDM_TX) sel[p] = rdm_pkg::SEL_SENT;
                  end
                  2'h1: begin
                     if (p == 1) sel[p] = rdm_pkg::SEL_FULL;
                     if (i_op_mode == rdm_pkg::RDM_RX) begin
                        if (p == 5 || p == 2) sel[p] = rdm_pkg::SEL_DATA;
                        if (p == 4 || p == 3) sel[p] = rdm_pkg::SEL_RSSI;
                        if (p == 0) sel[p] = rdm_pkg::SEL_PRDY;
                     end
                     if (i_op_mode == rdm_pkg::RDM_TX) begin
                        if (p == 5 || p == 2) sel[p] = rdm_pkg::SEL_DATA;
                        if (p == 4 || p == 3 || p == 0) sel[p] = rdm_pkg::SEL_TXR;
                     end
                  end
                  2'h2: begin
                     if (p == 1) sel[p] = rdm_pkg::SEL_NEMP;
                     if (i_op_mode == rdm_pkg::RDM_RX) begin
                        if (p == 4) sel[p] = rdm_pkg::SEL_RXR;
                        if (p == 3 || p == 0) sel[p] = rdm_pkg::SEL_SYNC;
                     end
                  end
                  2'h3: begin
                     if (p == 5) sel[p] = rdm_pkg::SEL_MRDY;
                     if (p == 2) sel[p] = rdm_pkg::SEL_AUTO;
                     if ((p == 4 || p == 3 || p == 1 || p == 0) &&
                         i_op_mode != rdm_pkg::RDM_SLEEP && i_op_mode != rdm_pkg::RDM_STDBY)
                        sel[p] = rdm_pkg::SEL_LOCK;
                     if (p == 0 && i_op_mode == rdm_pkg::RDM_RX) sel[p] = rdm_pkg::SEL_RSSI;
                  end
               endcase
            end
         end

         always_comb begin
            unique case (sel[p])
               rdm_pkg::SEL_MRDY: sel_val[p] = i_mode_ready_flag;
               rdm_pkg::SEL_AUTO: sel_val[p] = i_automatic_mode_indicator;
               rdm_pkg::SEL_LOCK: sel_val[p] = i_synth_locked;
               rdm_pkg::SEL_CLK:  sel_val[p] = i_reference_clock_output;
               rdm_pkg::SEL_SYNC: sel_val[p] = i_sync_match_flag;
               rdm_pkg::SEL_RXR:  sel_val[p] = i_receive_ready_flag;
               rdm_pkg::SEL_TXR:  sel_val[p] = i_transmit_ready_flag;
               rdm_pkg::SEL_FULL: sel_val[p] = i_queue_full;
               rdm_pkg::SEL_NEMP: sel_val[p] = ~i_queue_empty;
               rdm_pkg::SEL_LVL:  sel_val[p] = i_queue_threshold_flag;
               rdm_pkg::SEL_CRC:  sel_val[p] = i_checksum_good_flag;
               rdm_pkg::SEL_PRDY: sel_val[p] = i_payload_ready_flag;
               rdm_pkg::SEL_SENT: sel_val[p] = sent_r;
               rdm_pkg::SEL_TOUT: sel_val[p] = i_timeout_flag;
               rdm_pkg::SEL_RSSI: sel_val[p] = i_rssi_flag;
               rdm_pkg::SEL_DATA: sel_val[p] = cont ? s_rxd : (s_rxd & rx_gate_r);
               rdm_pkg::SEL_DCLK: sel_val[p] = s_dclk;
               default:           sel_val[p] = 1'b0;
            endcase
         end
      end
   endgenerate

   // pin 2 is driven except while continuous tx takes data in
   assign oe_nxt  = ~(cont && i_op_mode == rdm_pkg::RDM_TX);
   assign pin_nxt = {sel_val[5:3], sel_val[2] & oe_nxt, sel_val[1:0]};

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pin_r <= 6'h00;
         oe_r  <= 1'b0;
      end else begin
         pin_r <= pin_nxt;
         oe_r  <= oe_nxt;
      end
   end

   // gate from ready rise to payload rise
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rx_ready_d_r  <= 1'b0;
         pay_ready_d_r <= 1'b0;
         rx_gate_r     <= 1'b0;
      end else begin
         rx_ready_d_r  <= i_receive_ready_flag;
         pay_ready_d_r <= i_payload_ready_flag;
         if ((i_payload_ready_flag && !pay_ready_d_r) || cont ||
             i_op_mode != rdm_pkg::RDM_RX) begin
            rx_gate_r <= 1'b0;
         end else if (i_receive_ready_flag && !rx_ready_d_r) begin
            rx_gate_r <= 1'b1;
         end
      end
   end

   // sent rises on last bit, clears leaving tx
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         last_d_r <= 1'b0;
         sent_r   <= 1'b0;
      end else begin
         last_d_r <= i_shift_last_bit_out;
         if (i_shift_last_bit_out && !last_d_r) begin
            sent_r <= 1'b1;
         end else if (i_op_mode != rdm_pkg::RDM_TX) begin
            sent_r <= 1'b0;
         end
      end
   end

   assign len_max = !i_encrypt_en ? rdm_pkg::RDM_LEN_MAX_PLAIN :
                    i_address_en  ? rdm_pkg::RDM_LEN_MAX_ENC_A : rdm_pkg::RDM_LEN_MAX_ENC;

   // status and controls
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         bsync_r  <= 1'b0;
         fixed_r  <= 1'b0;
         len_ok_r <= 1'b0;
         qen_r    <= 1'b0;
         txbit_r  <= 1'b0;
      end else begin
         bsync_r  <= i_packet_mode | i_bsync_cfg;
         fixed_r  <= i_packet_mode & ~i_frame_format_select & (i_frame_length_setting != 8'h00);
         len_ok_r <= (i_frame_length_setting >= rdm_pkg::RDM_LEN_MIN) &&
                     (i_frame_length_setting <= len_max);
         // queue usable in any mode, idle in continuous
         qen_r    <= i_packet_mode;
         // tx bit sampled at bit clock rise
         txbit_r  <= s_txb;
      end
   end

   assign o_gp_pin           = pin_r;
   assign o_gp_pin_2_oe      = oe_r;
   assign o_bsync_active     = bsync_r;
   assign o_fixed_format     = fixed_r;
   assign o_length_ok        = len_ok_r;
   assign o_queue_enable     = qen_r;
   assign o_tx_bit           = txbit_r;
   assign o_packet_sent_flag = sent_r;
endmodule : rdm_pin_router

// ### rdm_pkg.sv
package rdm_pkg;
   // operating modes
   typedef enum logic [2:0] {
      RDM_SLEEP = 3'h0,
      RDM_STDBY = 3'h1,
      RDM_SYNTH = 3'h2,
      RDM_RX    = 3'h3,
      RDM_TX    = 3'h4
   } rdm_mode_e;

   // pin route config a holds pins 0..3, b holds pins 4..5 (two bits each)
   localparam int          RDM_NUM_PINS      = 6;
   localparam int          RDM_CODE_W        = 2;
   localparam logic [7:0]  RDM_ROUTE_A_RST   = 8'h00;
   localparam logic [7:0]  RDM_ROUTE_B_RST   = 8'h00;
   localparam logic [2:0]  RDM_MODE_RST      = 3'h1;

   // payload length limits
   localparam logic [7:0]  RDM_LEN_MIN       = 8'h01;
   localparam logic [7:0]  RDM_LEN_MAX_PLAIN = 8'hff;
   localparam logic [7:0]  RDM_LEN_MAX_ENC   = 8'h40;
   localparam logic [7:0]  RDM_LEN_MAX_ENC_A = 8'h41;

   // link bit clock divider: bench link clock 160 ns, bit = 4 link periods
   localparam logic [3:0]  RDM_DCLK_HALF     = 4'h1;

   // signal select codes
   localparam logic [4:0]  SEL_NONE  = 5'h00;
   localparam logic [4:0]  SEL_MRDY  = 5'h01;
   localparam logic [4:0]  SEL_AUTO  = 5'h02;
   localparam logic [4:0]  SEL_LOCK  = 5'h03;
   localparam logic [4:0]  SEL_CLK   = 5'h04;
   localparam logic [4:0]  SEL_SYNC  = 5'h05;
   localparam logic [4:0]  SEL_RXR   = 5'h06;
   localparam logic [4:0]  SEL_TXR   = 5'h07;
   localparam logic [4:0]  SEL_FULL  = 5'h08;
   localparam logic [4:0]  SEL_NEMP  = 5'h09;
   localparam logic [4:0]  SEL_LVL   = 5'h0a;
   localparam logic [4:0]  SEL_CRC   = 5'h0b;
   localparam logic [4:0]  SEL_PRDY  = 5'h0c;
   localparam logic [4:0]  SEL_SENT  = 5'h0d;
   localparam logic [4:0]  SEL_TOUT  = 5'h0e;
   localparam logic [4:0]  SEL_RSSI  = 5'h0f;
   localparam logic [4:0]  SEL_DATA  = 5'h10;
   localparam logic [4:0]  SEL_DCLK  = 5'h11;
endpackage : rdm_pkg

// ### rdm_sync2.sv
`timescale 1ns/1ps
// two-flop level synchroniser
module rdm_sync2 #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_r <= '0;
         q_r    <= '0;
      end else begin
         meta_r <= i_d;
         q_r    <= meta_r;
      end
   end

   assign o_q = q_r;
endmodule : rdm_sync2

// ### rdm_link.sv
`timescale 1ns/1ps
// link-side bit clock and data shifter, runs on the link clock
module rdm_link (
   // link clock
   input  wire logic i_lclk,
   input  wire logic i_lrst_n,
   // controls, already synchronised to the link clock
   input  wire logic i_tx_cont,
   input  wire logic i_rx_cont,
   input  wire logic i_bsync_en,
   // raw demodulator bit
   input  wire logic i_demod_raw,
   // data pin input from the controller
   input  wire logic i_pin_data,
   // outputs
   output logic      o_dclk,
   output logic      o_rx_data,
   output logic      o_tx_bit
);
   logic [3:0] div_r;
   logic       dclk_r;
   logic       rxd_r;
   logic       txb_r;
   logic       run;

   assign run = i_tx_cont | (i_rx_cont & i_bsync_en);

   // bit clock divider, stopped when no bit clock is due
   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n || !run) begin
         div_r  <= 4'h0;
         dclk_r <= 1'b0;
      end else if (div_r == rdm_pkg::RDM_DCLK_HALF) begin
         div_r  <= 4'h0;
         dclk_r <= ~dclk_r;
      end else begin
         div_r  <= div_r + 4'h1;
      end
   end

   // cleaned data changes at falling edge
   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) begin
         rxd_r <= 1'b0;
      end else if (div_r == rdm_pkg::RDM_DCLK_HALF && dclk_r) begin
         rxd_r <= i_demod_raw;
      end
   end

   // sample tx data at rising edge
   always_ff @(posedge i_lclk) begin
      if (!i_lrst_n) begin
         txb_r <= 1'b0;
      end else if (i_tx_cont && div_r == rdm_pkg::RDM_DCLK_HALF && !dclk_r) begin
         txb_r <= i_pin_data;
      end
   end

   assign o_dclk    = dclk_r & run;
   assign o_rx_data = i_bsync_en ? rxd_r : i_demod_raw;
   assign o_tx_bit  = txb_r;
endmodule : rdm_link

// ### rdm_pin_router_monitor.sv
`timescale 1ns/1ps
// port property checks for the pin router
module rdm_pin_router_monitor (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic [7:0] i_pin_route_config_a,
   input  wire logic [7:0] i_pin_route_config_b,
   input  wire logic [2:0] i_op_mode,
   input  wire logic       i_packet_mode,
   input  wire logic       i_frame_format_select,
   input  wire logic [7:0] i_frame_length_setting,
   input  wire logic       i_encrypt_en,
   input  wire logic       i_address_en,
   input  wire logic       i_automatic_mode_indicator,
   input  wire logic       i_shift_last_bit_out,
   input  wire logic [5:0] o_gp_pin,
   input  wire logic       o_gp_pin_2_oe,
   input  wire logic       o_bsync_active,
   input  wire logic       o_fixed_format,
   input  wire logic       o_packet_sent_flag
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // continuous transmit
   logic ctx;
   assign ctx = !i_packet_mode && i_op_mode == 3'h4;
   AST_UNDEF_LOW: assert property ((i_op_mode > 3'h4)[*2] |=> o_gp_pin == 6'h00)
      else $error("pins not low in undefined mode");
   AST_OE_CTX: assert property (ctx[*2] |=> !o_gp_pin_2_oe)
      else $error("data pin driven in continuous transmit");
   AST_OE_PKT: assert property (i_packet_mode[*2] |=> o_gp_pin_2_oe)
      else $error("data pin not driven in packet mode");
   AST_BSYNC: assert property (i_packet_mode[*2] |=> o_bsync_active)
      else $error("bit synchroniser not forced in packet mode");
   AST_FIXED: assert property ((i_packet_mode && !i_frame_format_select &&
      i_frame_length_setting != 8'h00)[*2]
      |=> o_fixed_format)
      else $error("fixed format not selected");
   AST_NOT_FIXED: assert property (i_frame_format_select[*2] |=> !o_fixed_format)
      else $error("fixed format with format bit set");
   AST_SENT: assert property ($past(i_rst_n) && i_packet_mode && i_op_mode == 3'h4 &&
      $rose(i_shift_last_bit_out) |=> o_packet_sent_flag)
      else $error("sent flag late");
   AST_SENT_CLR: assert property ((i_op_mode != 3'h4)[*2] |=> !o_packet_sent_flag)
      else $error("sent flag outside transmit");
   AST_SLEEP_01: assert property ((!i_packet_mode && i_op_mode == 3'h0 &&
      i_pin_route_config_a == 8'h55 && i_pin_route_config_b[3:0] == 4'h5)[*2]
      |=> o_gp_pin == 6'h00)
      else $error("sleep code 01 pin not low");
   AST_AUTO: assert property ((!i_packet_mode && i_op_mode == 3'h1 &&
      i_pin_route_config_a[7:6] == 2'h2 && i_automatic_mode_indicator)[*2]
      |=> o_gp_pin[3])
      else $error("automatic indicator missing on pin 3");
endmodule : rdm_pin_router_monitor

bind rdm_pin_router rdm_pin_router_monitor mon (.*);

// ### rdm_mcu_model.sv
`timescale 1ns/1ps
// controller side of the continuous data pin
module rdm_mcu_model (
   input  wire logic i_clk,
   input  wire logic i_dclk,
   input  wire logic i_en,
   output logic      o_data
);
   logic dclk_q;
   initial begin
      o_data = 1'b0;
      dclk_q = 1'b0;
   end
   always @(posedge i_clk) begin
      dclk_q <= i_dclk;
      if (!i_en || (dclk_q && !i_dclk))
         o_data <= ~o_data;
   end
endmodule : rdm_mcu_model

// ### rdm_pin_router_test.sv
`timescale 1ns/1ps
// mapping, gating and link checks for the pin router
module rdm_pin_router_test;
   logic       clk, lclk, rst_n, lrst_n, pkt, bsc, fmt, enc, adr, sl, raw, pin2, lst;
   logic       oe, bsa, fix, lok, qen, txb, sent;
   logic [7:0] cfg_a, cfg_b, len, lim;
   logic [2:0] mode;
   logic [5:0] pin;
   logic [13:0] fl;
   logic [7:0] lens[6] = '{8'h00, 8'h01, 8'h40, 8'h41, 8'h42, 8'hff};
   int         seed = 45, fails = 0, tests_run = 0, tog;
   byte        r;
   string tbl[40] = '{"------", "------", "--A---", "M----M", "C-----", "------", "--A---",
      "M----M", "C----L", "------", "--A---", "ML--LM", "COIDQS", "IRRDRO", "-SAD-I", "MLODSM",
      "CTT-QL", "CTT-TT", "--A---", "MLT-LM", "--FNV-", "----F-", "----N-", "M--A--", "C-FNV-",
      "----F-", "----N-", "M--A--", "C-FNV-", "----F-", "----N-", "MLLALL", "COFNVK", "DIIDFP",
      "-RS-NS", "MLLALI", "CMFNVE", "DTTDFT", "----N-", "MLLALL"};
   rdm_pin_router dut (.i_clk(clk), .i_rst_n(rst_n), .i_lclk(lclk), .i_lrst_n(lrst_n),
      .i_pin_route_config_a(cfg_a), .i_pin_route_config_b(cfg_b), .i_op_mode(mode),
      .i_packet_mode(pkt), .i_bsync_cfg(bsc), .i_frame_format_select(fmt),
      .i_frame_length_setting(len), .i_encrypt_en(enc), .i_address_en(adr),
      .i_mode_ready_flag(fl[0]), .i_automatic_mode_indicator(fl[1]), .i_synth_locked(fl[2]),
      .i_reference_clock_output(fl[3]), .i_sync_match_flag(fl[4]),
      .i_receive_ready_flag(fl[5]), .i_transmit_ready_flag(fl[6]), .i_queue_empty(fl[7]),
      .i_queue_full(fl[8]), .i_queue_threshold_flag(fl[9]), .i_checksum_good_flag(fl[10]),
      .i_payload_ready_flag(fl[11]), .i_shift_last_bit_out(sl), .i_timeout_flag(fl[12]),
      .i_rssi_flag(fl[13]), .i_demod_raw(raw), .i_gp_pin_2(pin2), .o_gp_pin(pin),
      .o_gp_pin_2_oe(oe), .o_bsync_active(bsa), .o_fixed_format(fix), .o_length_ok(lok),
      .o_queue_enable(qen), .o_tx_bit(txb), .o_packet_sent_flag(sent));
   rdm_mcu_model mcu (.i_clk(clk), .i_dclk(pin[1]), .i_en(!pkt && mode == 3'h4), .o_data(pin2));
   // clocks, link clock unrelated in phase
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      lclk = 1'b0;
      #3 forever #80 lclk = ~lclk;
   end
   initial begin
      lrst_n = 1'b0;
      repeat (3) @(posedge lclk);
      lrst_n <= 1'b1;
   end
   // expected pin level for a table letter
   function automatic logic exp_bit(input byte c);
      string k;
      k = "MALCSRTNFVKPOI";
      for (int i = 0; i < 14; i++) begin
         if (k[i] == c) return fl[i] ^ (c == "N");
      end
      return 1'b0;
   endfunction : exp_bit
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // level and edge count of one pin, or of the tx bit when i is 6, over n cycles
   task automatic watch(input int i, input int n);
      logic v;
      tog = 0;
      for (int k = 0; k < n; k++) begin
         @(posedge clk);
         #1 v = (i < 6) ? pin[i] : txb;
         if (k > 0 && v !== lst) tog++;
         lst = v;
      end
   endtask : watch
   task automatic wrap_up;
      $display("tests_run %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   task automatic setup(input logic p, input logic [2:0] m, input logic [1:0] c);
      @(posedge clk);
      pkt <= p;
      mode <= m;
      cfg_a <= {4{c}};
      cfg_b <= {4'h0, c, c};
   endtask : setup
   initial begin
      {rst_n, pkt, bsc, fmt, enc, adr, sl, raw, mode, fl, len} = '0;
      {cfg_a, cfg_b} = 16'h0000;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (40) @(posedge clk);
      // mapping sweep with random flags and packet settings
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 6; m++) begin
            for (int c = 0; c < 4; c++) begin
               setup(1'(p), 3'(m), c[1:0]);
               fl <= 14'($random(seed));
               {bsc, fmt, enc, adr, raw} <= 5'($random(seed));
               len <= lens[$unsigned($random(seed)) % 6];
               repeat (4) @(posedge clk);
               #1 lim = enc ? (adr ? 8'h41 : 8'h40) : 8'hff;
               for (int i = 0; i < 6; i++) begin
                  r = (m < 5) ? tbl[p * 20 + m * 4 + c][5 - i] : "-";
                  if (r != "D" && r != "Q" && r != "E") chk("pin", 8'(exp_bit(r)), 8'(pin[i]));
               end
               chk("oe", 8'(p == 1 || m != 4), 8'(oe));
               chk("bsync", 8'(pkt | bsc), 8'(bsa));
               chk("queue_en", 8'(pkt), 8'(qen));
               chk("fixed", 8'(pkt && !fmt && len != 8'h00), 8'(fix));
               chk("len_ok", 8'(len != 8'h00 && len <= lim), 8'(lok));
            end
         end
      end
      // continuous receive without, then with, bit synchroniser
      setup(1'b0, 3'h3, 2'h0);
      {bsc, raw, fl} <= '0;
      watch(1, 200);
      chk("no_dclk", 8'h00, 8'(tog));
      raw <= 1'b1;
      watch(2, 100);
      chk("raw_data", 8'h01, 8'(lst));
      bsc <= 1'b1;
      watch(1, 300);
      chk("rec_dclk", 8'h01, 8'(tog > 0));
      raw <= 1'b0;
      watch(2, 300);
      chk("clean_data", 8'h00, 8'(lst));
      // continuous transmit, controller follows bit clock
      setup(1'b0, 3'h4, 2'h0);
      watch(1, 300);
      chk("tx_dclk", 8'h01, 8'(tog > 0));
      watch(6, 300);
      chk("tx_bit", 8'h01, 8'(tog > 0));
      // packet receive data gated by ready flags
      setup(1'b1, 3'h3, 2'h1);
      fl <= 14'h0000;
      raw <= 1'b1;
      watch(2, 300);
      chk("gate_before", 8'h00, 8'(lst));
      fl <= 14'h0020;
      watch(2, 300);
      chk("gate_open", 8'h01, 8'(lst));
      fl <= 14'h0820;
      watch(2, 30);
      chk("gate_after", 8'h00, 8'(lst));
      // packet sent flag
      setup(1'b1, 3'h4, 2'h0);
      repeat (3) @(posedge clk);
      sl <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("sent", 8'h01, 8'(sent));
      chk("sent_pin", 8'h01, 8'(pin[0]));
      setup(1'b1, 3'h1, 2'h0);
      repeat (3) @(posedge clk);
      #1 chk("sent_clr", 8'h00, 8'(sent));
      wrap_up();
   end
endmodule : rdm_pin_router_test
